// ==== inc/ebpwm_defines.svh ====
`ifndef EBPWM_DEFINES_SVH
`define EBPWM_DEFINES_SVH

// Register byte offsets
`define EBPWM_OFF_CTRL    8'h00
`define EBPWM_OFF_DUTY    8'h04
`define EBPWM_OFF_PERIOD  8'h08
`define EBPWM_OFF_TIMER   8'h0C
`define EBPWM_OFF_DBAND   8'h10
`define EBPWM_OFF_SHDN    8'h14
`define EBPWM_OFF_PINDIR  8'h18

// Control register fields
`define EBPWM_CTRL_MODE_HI   7
`define EBPWM_CTRL_MODE_LO   6
`define EBPWM_CTRL_DLOW_HI   5
`define EBPWM_CTRL_DLOW_LO   4
`define EBPWM_CTRL_ENA_HI    3
`define EBPWM_CTRL_ENA_LO    2
`define EBPWM_CTRL_POL_AC    1
`define EBPWM_CTRL_POL_BD    0
`define EBPWM_PWM_ENA_CODE   2'h3

// Timer register fields
`define EBPWM_TMR_PS_HI      9
`define EBPWM_TMR_PS_LO      8
`define EBPWM_TMR_RUN        10
`define EBPWM_TMR_FLAG       11

// Dead-band and shutdown register fields
`define EBPWM_DB_RESTART     7
`define EBPWM_SD_STATUS      7
`define EBPWM_SD_SRC_HI      6
`define EBPWM_SD_SRC_LO      4
`define EBPWM_SD_AC_HI       3
`define EBPWM_SD_AC_LO       2
`define EBPWM_SD_BD_HI       1
`define EBPWM_SD_BD_LO       0

// Reset values
`define EBPWM_RST_BYTE       8'h00
`define EBPWM_RST_PINDIR     4'hF

// Timing: quarter phase of one instruction cycle, dead-band counter top
`define EBPWM_LAST_QUARTER   2'h3
`define EBPWM_DCNT_MAX       7'h7F

`endif

// ==== inc/ebpwm_pkg.sv ====
package ebpwm_pkg;

   typedef enum logic [1:0]
   {
      EBPWM_SINGLE   = 2'h0,
      EBPWM_FULL_FWD = 2'h1,
      EBPWM_HALF     = 2'h2,
      EBPWM_FULL_REV = 2'h3
   } ebpwm_mode_t;

   typedef enum logic [1:0]
   {
      EBPWM_PS_1  = 2'h0,
      EBPWM_PS_4  = 2'h1,
      EBPWM_PS_16 = 2'h2,
      EBPWM_PS_16B = 2'h3
   } ebpwm_ps_t;

endpackage

// ==== verilog/ebpwm_core.sv ====
`timescale 1ns/1ps
`include "ebpwm_defines.svh"

// Overview of operation
// R1: Any reset makes all pins inputs and restores every register default.
// R2: Host disables drivers, sets period, mode, duty, starts timer, waits flag.
// R3: Two-bit mode: 00 single, 10 half, 01 full forward, 11 full reverse.
// R4: Ten-bit time base is period timer joined with quarter phase or prescaler.
// R5: On enable, waveform starts only at the next period start.
// R6: Control register written to zero releases all four output pins.
// R7: Pins unused by the selected mode stay free for other functions.
// R8: Two polarity bits set active level for pair a/c and pair b/d.
// R9: Half-bridge drives PWM on out_a and its complement on out_b.
// R10: Half-bridge active edges delayed by delay count; too long stays inactive.
// R11: Full forward: out_a active, out_d modulated, out_b and out_c inactive.
// R12: Full reverse: out_c active, out_b modulated, out_a and out_d inactive.
// R13: Direction change applies next period, modulated outputs idle meanwhile.
// R14: Unmodulated outputs swap one time-base step before period end.
// R15: Full-bridge modes use no dead-band delay.
// R16: Host picks polarity before enabling drivers, not while enabled.
// R17: Match flag sets as second period begins; host waits for it.
// R18: Source field picks interrupt pin, comparators; software set also shuts down.
// R19: Shutdown sets status bit, held until firmware or auto-restart clears it.
// R20: Shutdown forces enabled pins to per-pair high, low or high-impedance.
// R21: Safe select: 00 drive low, 01 drive high, 1x high-impedance.
// R22: Source 000 off, 001 cmp1, 010 cmp2, 011 either, 1xx adds pin.
// R23: Shutdown condition is a level and persists while present.
// R24: With auto-restart, status clears in hardware when condition goes away.
module ebpwm_core
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        cmp1_in,
   input  wire logic        cmp2_in,
   input  wire logic        ext_int_in,
   output logic      [3:0]  out_pin,
   output logic      [3:0]  out_pin_oe_n,
   output logic      [3:0]  pwm_owns_pin,
   output logic             timer_match_flag
);

   logic [7:0] ctrl_q;
   logic [7:0] duty_hi_q;
   logic [9:0] duty_lat_q;
   logic [7:0] period_q;
   logic [7:0] tmr_q;
   logic [1:0] ps_q;
   logic       run_q;
   logic       flag_q;
   logic [7:0] db_q;
   logic [2:0] sd_src_q;
   logic [1:0] pss_ac_q;
   logic [1:0] pss_bd_q;
   logic       sd_stat_q;
   logic [3:0] pin_dir_q;
   logic [1:0] qph_q;
   logic [3:0] pre_q;
   logic       pwm_q;
   logic       armed_q;
   logic       dir_q;
   logic [6:0] dcnt_q [2];
   logic [3:0] out_q;
   logic [3:0] oe_n_q;
   logic       wr_q;
   logic       rd_q;
   logic [7:0] addr_q;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [3:0] act;
   logic [31:0] rd_mux;

   // Bus: zero wait states, every access answered OKAY
   wire        req     = hsel && htrans[1] && hready;
   wire        wr_ctrl = wr_q && addr_q == `EBPWM_OFF_CTRL;
   wire        wr_duty = wr_q && addr_q == `EBPWM_OFF_DUTY;
   wire        wr_per  = wr_q && addr_q == `EBPWM_OFF_PERIOD;
   wire        wr_tmr  = wr_q && addr_q == `EBPWM_OFF_TIMER;
   wire        wr_db   = wr_q && addr_q == `EBPWM_OFF_DBAND;
   wire        wr_sd   = wr_q && addr_q == `EBPWM_OFF_SHDN;
   wire        wr_dir  = wr_q && addr_q == `EBPWM_OFF_PINDIR;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Pin inputs pass two flops before use
   wire        cmp1_s  = sync2_q[0];
   wire        cmp2_s  = sync2_q[1];
   wire        int_s   = sync2_q[2];

   // Time base
   wire ebpwm_pkg::ebpwm_ps_t ps = ebpwm_pkg::ebpwm_ps_t'(ps_q);
   wire        icyc    = qph_q == `EBPWM_LAST_QUARTER;
   wire [1:0]  low2    = (ps == ebpwm_pkg::EBPWM_PS_1) ? qph_q :
                         (ps == ebpwm_pkg::EBPWM_PS_4) ? pre_q[1:0] :
                         pre_q[3:2];
   wire        pre_top = (ps == ebpwm_pkg::EBPWM_PS_1) ? 1'b1 :
                         (ps == ebpwm_pkg::EBPWM_PS_4) ? &pre_q[1:0] :
                         &pre_q;
   wire        step     = run_q && icyc && pre_top;
   wire        at_per   = tmr_q == period_q;
   wire        rollover = step && at_per;
   wire [9:0]  tbase    = {tmr_q, low2}; // R4
   wire [9:0]  duty_new = {duty_hi_q,
                           ctrl_q[`EBPWM_CTRL_DLOW_HI:`EBPWM_CTRL_DLOW_LO]};
   wire        last_lsb = run_q && at_per && low2 == 2'h3;
   wire        pwm_now  = pwm_q && !(run_q && tbase == duty_lat_q); // R4

   // Mode and direction
   wire        pwm_on  = ctrl_q[`EBPWM_CTRL_ENA_HI:`EBPWM_CTRL_ENA_LO]
                         == `EBPWM_PWM_ENA_CODE;
   wire        full    = ctrl_q[`EBPWM_CTRL_MODE_LO];
   wire        dir_new = ctrl_q[`EBPWM_CTRL_MODE_HI];
   wire        pending = full && dir_new != dir_q;
   // Swap one step early, modulation idle in that step
   wire        hold    = pending && last_lsb; // R14
   wire        dir_eff = hold ? dir_new : dir_q; // R13
   wire ebpwm_pkg::ebpwm_mode_t mode =
      ebpwm_pkg::ebpwm_mode_t'({full ? dir_eff : dir_new, full}); // R3
   wire        pwm_mod = pwm_now && !hold; // R13

   // Shutdown
   wire        sd_cond = (sd_src_q[0] && cmp1_s) ||
                         (sd_src_q[1] && cmp2_s) ||
                         (sd_src_q[2] && !int_s); // R22
   wire        sd_set  = sd_cond || (wr_sd && hwdata[`EBPWM_SD_STATUS]); // R18
   wire        restart = db_q[`EBPWM_DB_RESTART];

   // Dead-band on the half-bridge pair
   wire [1:0]  raw     = {!pwm_now, pwm_now};
   wire [6:0]  dly     = db_q[6:0];
   wire [1:0]  dead;

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_dead
         assign dead[g] = raw[g] && dcnt_q[g] >= dly; // R10
      end
   endgenerate

   always_comb
   begin
      act = 4'h0;
      unique case (mode)
         ebpwm_pkg::EBPWM_SINGLE:   act = {3'h0, pwm_now};
         ebpwm_pkg::EBPWM_HALF:     act = {2'h0, dead}; // R9
         ebpwm_pkg::EBPWM_FULL_FWD: act = {pwm_mod, 2'h0, 1'b1}; // R11 R15
         ebpwm_pkg::EBPWM_FULL_REV: act = {1'b0, 1'b1, pwm_mod, 1'b0}; // R12
      endcase
   end

   // Unused pins stay with the port
   wire [3:0]  owns = !pwm_on ? 4'h0 :
                      full ? 4'hF :
                      (mode == ebpwm_pkg::EBPWM_HALF) ? 4'h3 : 4'h1; // R6 R7
   wire        pol_ac = ctrl_q[`EBPWM_CTRL_POL_AC];
   wire        pol_bd = ctrl_q[`EBPWM_CTRL_POL_BD];
   wire [3:0]  pol    = {pol_bd, pol_ac, pol_bd, pol_ac}; // R8
   wire [3:0]  lvl    = (armed_q ? act : 4'h0) ^ pol;
   wire [3:0]  sd_val = {pss_bd_q[0], pss_ac_q[0], pss_bd_q[0], pss_ac_q[0]};
   wire [3:0]  sd_z   = {pss_bd_q[1], pss_ac_q[1], pss_bd_q[1], pss_ac_q[1]};
   wire [3:0]  out_d  = owns & (sd_stat_q ? sd_val : lvl); // R20 R21
   wire [3:0]  oe_n_d = ~owns | pin_dir_q |
                        ({4{sd_stat_q}} & sd_z); // R21

   assign out_pin          = out_q;
   assign out_pin_oe_n     = oe_n_q;
   assign pwm_owns_pin     = owns;
   assign timer_match_flag = flag_q;

   // Read data
   assign rd_mux =
      (addr_q == `EBPWM_OFF_CTRL)   ? {24'h0, ctrl_q} :
      (addr_q == `EBPWM_OFF_DUTY)   ? {14'h0, duty_lat_q, duty_hi_q} :
      (addr_q == `EBPWM_OFF_PERIOD) ? {24'h0, period_q} :
      (addr_q == `EBPWM_OFF_TIMER)  ? {20'h0, flag_q, run_q, ps_q, tmr_q} :
      (addr_q == `EBPWM_OFF_DBAND)  ? {24'h0, db_q} :
      (addr_q == `EBPWM_OFF_SHDN)   ? {24'h0, sd_stat_q, sd_src_q,
                                       pss_ac_q, pss_bd_q} :
      (addr_q == `EBPWM_OFF_PINDIR) ? {28'h0, pin_dir_q} : 32'h0;
   assign hrdata = rd_q ? rd_mux : 32'h0;

   // Synchronisers run through reset so inputs are settled at release
   always_ff @(posedge clock)
   begin
      sync1_q <= {ext_int_in, cmp2_in, cmp1_in};
      sync2_q <= sync1_q;
      wr_q    <= rst_n && req && hwrite;
      rd_q    <= rst_n && req && !hwrite;
      addr_q  <= !rst_n ? 8'h00 : req ? haddr[7:0] : addr_q;
   end

   // Register file
   always_ff @(posedge clock)
   begin
      if (!rst_n) // R1
      begin
         ctrl_q    <= `EBPWM_RST_BYTE;
         duty_hi_q <= `EBPWM_RST_BYTE;
         period_q  <= `EBPWM_RST_BYTE;
         ps_q      <= 2'h0;
         run_q     <= 1'b0;
         db_q      <= `EBPWM_RST_BYTE;
         sd_src_q  <= 3'h0;
         pss_ac_q  <= 2'h0;
         pss_bd_q  <= 2'h0;
         pin_dir_q <= `EBPWM_RST_PINDIR;
      end
      else
      begin
         ctrl_q    <= wr_ctrl ? hwdata[7:0] : ctrl_q;
         duty_hi_q <= wr_duty ? hwdata[7:0] : duty_hi_q;
         period_q  <= wr_per ? hwdata[7:0] : period_q;
         ps_q      <= wr_tmr ? hwdata[`EBPWM_TMR_PS_HI:`EBPWM_TMR_PS_LO]
                             : ps_q;
         run_q     <= wr_tmr ? hwdata[`EBPWM_TMR_RUN] : run_q;
         db_q      <= wr_db ? hwdata[7:0] : db_q;
         sd_src_q  <= wr_sd ? hwdata[`EBPWM_SD_SRC_HI:`EBPWM_SD_SRC_LO]
                            : sd_src_q;
         pss_ac_q  <= wr_sd ? hwdata[`EBPWM_SD_AC_HI:`EBPWM_SD_AC_LO]
                            : pss_ac_q;
         pss_bd_q  <= wr_sd ? hwdata[`EBPWM_SD_BD_HI:`EBPWM_SD_BD_LO]
                            : pss_bd_q;
         pin_dir_q <= wr_dir ? hwdata[3:0] : pin_dir_q;
      end
   end

   // Timer, duty latch and raw waveform
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         qph_q      <= 2'h0;
         pre_q      <= 4'h0;
         tmr_q      <= 8'h00;
         duty_lat_q <= 10'h000;
         pwm_q      <= 1'b0;
         flag_q     <= 1'b0;
      end
      else
      begin
         qph_q <= qph_q + 2'h1;
         if (wr_tmr)
            pre_q <= 4'h0;
         else if (run_q && icyc)
            pre_q <= pre_q + 4'h1;
         if (wr_tmr)
            tmr_q <= hwdata[7:0];
         else if (step)
            tmr_q <= at_per ? 8'h00 : tmr_q + 8'h01;
         if (rollover)
         begin
            duty_lat_q <= duty_new;
            pwm_q      <= duty_new != 10'h000;
         end
         else if (run_q && tbase == duty_lat_q)
            pwm_q <= 1'b0;
         // A match in the clearing cycle keeps the flag set
         if (rollover) // R17
            flag_q <= 1'b1;
         else if (wr_tmr && hwdata[`EBPWM_TMR_FLAG])
            flag_q <= 1'b0;
      end
   end

   // Control state: arming, direction, shutdown, dead-band counters
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         armed_q   <= 1'b0;
         dir_q     <= 1'b0;
         sd_stat_q <= 1'b0;
         dcnt_q[0] <= 7'h00;
         dcnt_q[1] <= 7'h00;
         out_q     <= 4'h0;
         oe_n_q    <= 4'hF;
      end
      else
      begin
         if (!pwm_on || sd_stat_q)
            armed_q <= 1'b0;
         else if (rollover) // R5
            armed_q <= 1'b1;
         if (!full || rollover || !run_q)
            dir_q <= dir_new; // R13
         // Writes cannot clear while the condition persists
         if (sd_set) // R19 R23
            sd_stat_q <= 1'b1;
         else if (restart) // R24
            sd_stat_q <= 1'b0;
         else if (wr_sd)
            sd_stat_q <= 1'b0;
         for (int i = 0; i < 2; i++)
         begin
            if (!raw[i])
               dcnt_q[i] <= 7'h00;
            else if (icyc && dcnt_q[i] != `EBPWM_DCNT_MAX)
               dcnt_q[i] <= dcnt_q[i] + 7'h01;
         end
         out_q  <= out_d;
         oe_n_q <= oe_n_d;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_reset_pins_in: // R1
      assert property ($rose(rst_n) |-> pin_dir_q == 4'hF && oe_n_q == 4'hF)
      else $error("pins not inputs after reset");
   a_arm_at_period: // R5
      assert property ($rose(armed_q) |-> $past(rollover))
      else $error("waveform armed outside period start");
   a_release_zero: // R6
      assert property (ctrl_q == 8'h00 |-> pwm_owns_pin == 4'h0 ##1
                       out_pin_oe_n == 4'hF)
      else $error("pins held with control cleared");
   a_half_unused: // R7
      assert property (pwm_on && mode == ebpwm_pkg::EBPWM_HALF
                       |-> pwm_owns_pin[3:2] == 2'h0)
      else $error("half-bridge claims unused pins");
   a_dead_hold: // R10
      assert property ($rose(pwm_q) && dly != 7'h00 |-> !dead[0])
      else $error("active edge not delayed");
   a_full_fwd: // R11
      assert property (armed_q && !sd_stat_q &&
                       mode == ebpwm_pkg::EBPWM_FULL_FWD
                       |=> out_pin[0] == !$past(pol_ac) &&
                       out_pin[2] == $past(pol_ac) &&
                       out_pin[1] == $past(pol_bd))
      else $error("forward levels wrong");
   a_full_rev: // R12
      assert property (armed_q && !sd_stat_q &&
                       mode == ebpwm_pkg::EBPWM_FULL_REV
                       |=> out_pin[2] == !$past(pol_ac) &&
                       out_pin[0] == $past(pol_ac) &&
                       out_pin[3] == $past(pol_bd))
      else $error("reverse levels wrong");
   a_dir_swap: // R13
      assert property (full && run_q && $changed(dir_q) |-> $past(rollover))
      else $error("direction changed mid period");
   a_flag_match: // R17
      assert property ($rose(flag_q) |-> $past(rollover))
      else $error("match flag without rollover");
   a_sd_level: // R23
      assert property (sd_cond [*2] |-> sd_stat_q)
      else $error("shutdown lost while condition held");
   a_sd_safe: // R20
      assert property (sd_stat_q && owns[0] |=> out_pin[0] ==
                       $past(pss_ac_q[0]))
      else $error("safe state not applied");
   a_auto_clear: // R24
      assert property (restart && sd_stat_q && !sd_set |=> !sd_stat_q)
      else $error("auto-restart did not clear");

endmodule

// ==== bench/ebpwm_bridge_model.sv ====
`timescale 1ns/1ps
module ebpwm_bridge_model
(
   input  wire logic       clock,
   input  wire logic [3:0] out_pin,
   input  wire logic [3:0] out_pin_oe_n,
   output logic      [3:0] pin_level,
   output int              shoot_cnt
);
   // Released pins fall to the board pull-downs, so switches stay off
   assign pin_level = out_pin & ~out_pin_oe_n;
   // Both switches of leg a/b on together shorts the bridge supply
   initial
   begin
      shoot_cnt = 0;
      forever
         @(posedge clock)
            if (pin_level[0] && pin_level[1])
               shoot_cnt <= shoot_cnt + 1;
   end
endmodule

// ==== bench/test_enhanced_bridge_pwm_output.sv ====
`timescale 1ns/1ps
`include "ebpwm_defines.svh"
module test_enhanced_bridge_pwm_output;
   logic        clock = 0, rst_n = 0, hsel = 0, hwrite = 0;
   logic        cmp1_in = 0, cmp2_in = 0, ext_int_in = 1;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
   logic [1:0]  htrans = 0;
   logic        hreadyout, hresp, timer_match_flag;
   logic [3:0]  out_pin, out_pin_oe_n, pwm_owns_pin, pin_level;
   int          shoot_cnt, err_total = 0, tests_run = 0, hi[4], d;
   logic [31:0] seed = 32'hF71C;
   logic [7:0]  c;
   logic [1:0]  ac, bd;

   ebpwm_core i_ebpwm_core (.clock(clock), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .cmp1_in(cmp1_in),
      .cmp2_in(cmp2_in), .ext_int_in(ext_int_in), .out_pin(out_pin),
      .out_pin_oe_n(out_pin_oe_n), .pwm_owns_pin(pwm_owns_pin),
      .timer_match_flag(timer_match_flag));
   ebpwm_bridge_model i_ebpwm_bridge_model (.clock(clock),
      .out_pin(out_pin), .out_pin_oe_n(out_pin_oe_n),
      .pin_level(pin_level), .shoot_cnt(shoot_cnt));

   always #20 clock = ~clock;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
   endfunction

   // Pin pair a/c uses select ac, pair b/d uses bd; tri-state reads 0
   function automatic logic [7:0] safe(input logic [1:0] a, b);
      logic [3:0] oe, lv;
      for (int i = 0; i < 4; i++)
      begin
         oe[i] = i[0] ? b[1] : a[1];
         lv[i] = !oe[i] && (i[0] ? b[0] : a[0]);
      end
      return {oe, lv};
   endfunction

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Only the watchdog ends a wait that never sees ready
   task automatic wait_rdy;
      do
         @(posedge clock);
      while (hreadyout !== 1'b1);
   endtask

   // Entered just after a rising edge; one single word transfer
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] y;
      bus(1'b1, a, x, y);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] y);
      bus(1'b0, a, 32'h0, y);
   endtask

   // Counts high clocks of each pin over n clocks
   task automatic measure(input int n);
      hi = '{0, 0, 0, 0};
      repeat (n)
      begin
         @(negedge clock);
         for (int i = 0; i < 4; i++)
            hi[i] += int'(pin_level[i]);
      end
      @(posedge clock);
   endtask

   function automatic logic [31:0] pk(input int a, b, e, f);
      return {8'(a), 8'(b), 8'(e), 8'(f)};
   endfunction

   // Drivers stay off until a whole period has run in the new mode
   task automatic setup(input logic [7:0] ctl, input int du,
                        input logic [1:0] ps);
      int n;
      wr(`EBPWM_OFF_PINDIR, 32'hF);
      wr(`EBPWM_OFF_PERIOD, 32'h3);
      wr(`EBPWM_OFF_CTRL, {24'h0, ctl});
      wr(`EBPWM_OFF_DUTY, 32'(du >> 2));
      wr(`EBPWM_OFF_TIMER, {20'h0, 2'h3, ps, 8'h00});
      // The flag clear lands at the write's last edge, so look after it
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end while (timer_match_flag !== 1'b1 && n < 500);
      check({31'h0, timer_match_flag}, 32'h1);
      wr(`EBPWM_OFF_PINDIR, 32'h0);
   endtask

   initial
   begin
      #(40 * 60000);
      err_total++;
      report_and_stop;
   end

   initial
   begin
      ticks(10);
      rst_n <= 1'b1;
      ticks(1);
      check({pwm_owns_pin, out_pin_oe_n}, 32'hF);
      rd(`EBPWM_OFF_CTRL, v);
      check(v, 32'h0);
      rd(`EBPWM_OFF_PINDIR, v);
      check(v, 32'hF);
      rd(`EBPWM_OFF_SHDN, v);
      check(v, 32'h0);
      rd(8'h1C, v);
      check({v[30:0], hresp}, 32'h0);
      // Half bridge: random duty, prescale 1 and 4, both polarities
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         d = 1 + int'(seed[7:0]) % 15;
         c = {ebpwm_pkg::EBPWM_HALF, 2'(d), 2'h3, k[1], k[1]};
         setup(c, d, {1'b0, k[0]});
         ticks(k[0] ? 70 : 20);
         measure(k[0] ? 64 : 16);
         d = k[0] ? 4 * d : d;
         check(pk(hi[0], hi[1], hi[2], hi[3]), k[1] ?
            pk((k[0] ? 64 : 16) - d, d, 0, 0) :
            pk(d, (k[0] ? 64 : 16) - d, 0, 0));
         check({28'h0, pwm_owns_pin}, 32'h3);
      end
      check(32'(shoot_cnt), 32'h0);
      // Delay longer than the pulse keeps out_a idle all period
      wr(`EBPWM_OFF_DBAND, 32'h2);
      setup({ebpwm_pkg::EBPWM_HALF, 6'h0C}, 4, 2'h0);
      ticks(20);
      measure(16);
      check(32'(hi[0]), 32'h0);
      // Full bridge ignores the delay count
      seed = lfsr(seed);
      d = 1 + int'(seed[7:0]) % 15;
      setup({ebpwm_pkg::EBPWM_FULL_FWD, 2'(d), 4'hC}, d, 2'h0);
      ticks(20);
      measure(16);
      check(pk(hi[0], hi[1], hi[2], hi[3]), pk(16, 0, 0, d));
      wr(`EBPWM_OFF_CTRL, {24'h0, ebpwm_pkg::EBPWM_FULL_REV, 2'(d), 4'hC});
      ticks(40);
      measure(16);
      check(pk(hi[0], hi[1], hi[2], hi[3]), pk(0, d, 16, 0));
      // Every nonzero source code against every trigger
      for (int s = 1; s < 8; s++)
         for (int t = 0; t < 3; t++)
         begin
            seed = lfsr(seed);
            ac = seed[3:2];
            bd = seed[1:0];
            c = {1'b0, 3'(s), ac, bd};
            wr(`EBPWM_OFF_SHDN, {24'h0, c});
            cmp1_in <= (t == 0);
            cmp2_in <= (t == 1);
            ext_int_in <= (t != 2);
            ticks(6);
            rd(`EBPWM_OFF_SHDN, v);
            check(v, {24'h0, s[t], c[6:0]});
            if (s[t])
            begin
               check({24'h0, out_pin_oe_n, pin_level},
                     {24'h0, safe(ac, bd)});
               wr(`EBPWM_OFF_SHDN, {24'h0, c});
               rd(`EBPWM_OFF_SHDN, v);
               check(v, {24'h0, 1'b1, c[6:0]});
            end
            cmp1_in <= 1'b0;
            cmp2_in <= 1'b0;
            ext_int_in <= 1'b1;
            ticks(6);
            wr(`EBPWM_OFF_SHDN, {24'h0, c});
            ticks(40);
         end
      wr(`EBPWM_OFF_DBAND, 32'h82);
      wr(`EBPWM_OFF_SHDN, 32'h10);
      cmp1_in <= 1'b1;
      ticks(6);
      rd(`EBPWM_OFF_SHDN, v);
      check(v, 32'h90);
      cmp1_in <= 1'b0;
      ticks(8);
      rd(`EBPWM_OFF_SHDN, v);
      check(v, 32'h10);
      wr(`EBPWM_OFF_DBAND, 32'h2);
      wr(`EBPWM_OFF_SHDN, 32'h80);
      rd(`EBPWM_OFF_SHDN, v);
      check(v, 32'h80);
      wr(`EBPWM_OFF_SHDN, 32'h0);
      rd(`EBPWM_OFF_SHDN, v);
      check(v, 32'h0);
      // Single output, slowest prescale: out_a only, other pins released
      seed = lfsr(seed);
      d = 1 + int'(seed[7:0]) % 15;
      setup({ebpwm_pkg::EBPWM_SINGLE, 2'(d), 4'hC}, d, 2'h2);
      ticks(20);
      measure(256);
      check(pk(hi[0], hi[1], hi[2], hi[3]), pk(16 * d, 0, 0, 0));
      check({28'h0, pwm_owns_pin}, 32'h1);
      wr(`EBPWM_OFF_CTRL, 32'h0);
      ticks(2);
      check({pwm_owns_pin, out_pin_oe_n}, 32'hF);
      // Reset again in mid-run
      wr(`EBPWM_OFF_CTRL, {24'h0, ebpwm_pkg::EBPWM_FULL_FWD, 6'h0C});
      rst_n <= 1'b0;
      ticks(2);
      rst_n <= 1'b1;
      ticks(1);
      check({pwm_owns_pin, out_pin_oe_n, 3'h0, timer_match_flag},
            32'hF0);
      rd(`EBPWM_OFF_PINDIR, v);
      check(v, 32'hF);
      report_and_stop;
   end
endmodule
